// *** verilog/rsdx_consts.svh ***
/*
  Constants of the streaming DMA read command block: APB byte offsets,
  field positions, reset values and timing counts.
  Assumes a 25 MHz system clock and 32-bit APB data.
*/
// Function
// R1 - Transfer length is 16 bits: current count byte low, previous count byte high.
// R2 - Counts of 1 to 65536 sectors; an all-zero count means 65536.
// R3 - First failing sector address readable; high-byte select picks bytes 47:24 or 23:0.
// R4 - Command code 2Ah starts the streaming DMA read of the counted sectors.
// R5 - Continuous flag clear: ordinary read, stops at error with error status.
// R6 - Continuous flag set: full length delivered, no error bit, stream-error flag on errors.
// R7 - Continuous flag set: errors do not stop; error type logged as CRC, UNC, IDNF, ABRT.
// R8 - Continuous flag set and time limit expired: stop, not busy, log expiry bit.
// R9 - Device keeps trying to move all requested data before the time limit.
// R10 - Starting address bytes come from current and previous address register bytes.
// R11 - Expiry bit is error bit 0; stream-error is status bit 5; error 5,3,1 zero.
// R12 - Feature current: bit 6 continuous, bit 7 urgent, bits 2:0 stream number.
// R13 - Limit is previous feature times time unit in microseconds; zero uses stream default.
// R14 - Limit is timed from command write until final completion interrupt.
// R15 - A requested limit under the device minimum is raised to the minimum.
`ifndef RSDX_CONSTS_SVH
`define RSDX_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define RSDX_OFF_FEAT_CUR 8'h00
`define RSDX_OFF_FEAT_PREV 8'h04
`define RSDX_OFF_CNT_CUR 8'h08
`define RSDX_OFF_CNT_PREV 8'h0C
`define RSDX_OFF_SN_CUR 8'h10
`define RSDX_OFF_CH_PREV 8'h24
`define RSDX_OFF_CMD 8'h28
`define RSDX_OFF_DEVCTL 8'h2C
`define RSDX_OFF_ERROR 8'h30
`define RSDX_OFF_STATUS 8'h34
`define RSDX_OFF_TUNIT 8'h38
`define RSDX_OFF_DFLT 8'h3C
`define RSDX_OFF_IRQ_STAT 8'h40
`define RSDX_OFF_IRQ_CLR 8'h44
`define RSDX_OFF_IRQ_EN 8'h48
`define RSDX_OFF_REMAIN 8'h4C

// ----------------------------------------------------------------------------
// Taskfile indices, fields and codes
// ----------------------------------------------------------------------------
`define RSDX_TF_NUM 10
`define RSDX_IDX_FEAT_CUR 0
`define RSDX_IDX_FEAT_PREV 1
`define RSDX_IDX_CNT_CUR 2
`define RSDX_IDX_CNT_PREV 3
`define RSDX_IDX_SN_CUR 4
`define RSDX_IDX_SN_PREV 5
`define RSDX_IDX_CL_CUR 6
`define RSDX_IDX_CL_PREV 7
`define RSDX_IDX_CH_CUR 8
`define RSDX_IDX_CH_PREV 9
`define RSDX_CMD_READ_STREAM 8'h2A
`define RSDX_FEAT_CONT_BIT 6
`define RSDX_FEAT_URGENT_BIT 7
`define RSDX_DEVCTL_HOB_BIT 7
`define RSDX_ERR_ICRC_BIT 7
`define RSDX_ERR_UNC_BIT 6
`define RSDX_ERR_IDNF_BIT 4
`define RSDX_ERR_ABRT_BIT 2
`define RSDX_ERR_TLIM_BIT 0
`define RSDX_ST_BSY_BIT 7
`define RSDX_ST_RDY_BIT 6
`define RSDX_ST_SERR_BIT 5
`define RSDX_ST_DRQ_BIT 3
`define RSDX_ST_ERR_BIT 0
`define RSDX_IRQ_DONE_BIT 0
`define RSDX_IRQ_FAIL_BIT 1
`define RSDX_IRQ_TOUT_BIT 2
`define RSDX_FULL_COUNT 17'h1_0000
`define RSDX_TUNIT_RST 16'h0001

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define RSDX_CLK_NS 40
`define RSDX_US_NS 1000
`define RSDX_CYC_PER_US (`RSDX_US_NS / `RSDX_CLK_NS)
`define RSDX_MIN_LIMIT_US 24'h00_03E8

`endif

// *** verilog/rsdx_pkg.sv ***
/*
  Types of the streaming DMA read command block.
  Assumes rsdx_consts.svh is included by the design file.
*/
package rsdx_pkg;

  // --------------------------------------------------------------------------
  // Command engine states
  // --------------------------------------------------------------------------
  typedef enum logic {
    RSDX_IDLE,
    RSDX_XFER
  } rsdx_state_t;

endpackage

// *** verilog/rsdx_top.sv ***
/*
  Streaming DMA read command interpreter with APB register file, sector
  request port toward the media engine, completion time limit and interrupt.
  Assumes one 25 MHz clock, synchronous inputs and a media engine that
  answers each sector request with a one-cycle XFER_ACK and error flags.
*/
`timescale 1ns/1ps
`include "rsdx_consts.svh"

module rsdx_top #(
  parameter int ADDR_W = 8,
  parameter logic [23:0] MIN_LIMIT_US = `RSDX_MIN_LIMIT_US
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic XFER_REQ,
  output logic [47:0] XFER_LBA,
  input wire logic XFER_ACK,
  input wire logic [3:0] XFER_ERR
);
  import rsdx_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  rsdx_state_t state_q;
  logic pready_q, pslverr_q, irq_q;
  logic [31:0] prdata_q;
  logic [7:0] tf_q [0:`RSDX_TF_NUM-1];
  logic [7:0] dflt_q [0:7];
  logic hob_q, cont_q, seen_q, any_err_q, sts_err_q, sts_serr_q, lim_en_q;
  logic [15:0] tunit_q;
  logic [7:0] err_q;
  logic [2:0] irq_stat_q, irq_en_q, irq_stat_d, irq_ev;
  logic [16:0] rem_q;
  logic [47:0] lba_q, fail_q;
  logic [23:0] lim_us_q, us_cnt_q, req_us;
  logic [4:0] pre_q;
  logic [7:0] lim_sel;
  logic [7:0] ev_err;
  logic [15:0] cnt_w;
  logic acc_w, wr_w, rd_w, cmd_wr, start_w, bad_w;
  logic ack_w, bad_sec, last_w, to_w, stop_w;
  logic [ADDR_W-1:0] addr;

  // --------------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------------
  // One wait state: the answer is built in the first access cycle, so the
  // read mux sees a stable address and PREADY comes straight from a flop.
  assign addr = PADDR;
  assign acc_w = PSEL & PENABLE & pready_q;
  assign wr_w = acc_w & PWRITE;
  assign rd_w = PSEL & PENABLE & ~pready_q & ~PWRITE;
  assign cmd_wr = wr_w && (addr == ADDR_W'(`RSDX_OFF_CMD));
  assign start_w = cmd_wr && (state_q == RSDX_IDLE)
                   && (PWDATA[7:0] == `RSDX_CMD_READ_STREAM); // R4
  assign bad_w = cmd_wr && (state_q == RSDX_IDLE)
                 && (PWDATA[7:0] != `RSDX_CMD_READ_STREAM);
  assign cnt_w = {tf_q[`RSDX_IDX_CNT_PREV], tf_q[`RSDX_IDX_CNT_CUR]}; // R1

  // Ready, error answer and read data of each access.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= PSEL & PENABLE & ~pready_q;
      if (PSEL & PENABLE & ~pready_q) begin
        pslverr_q <= (addr[1:0] != 2'b00) || (addr > ADDR_W'(`RSDX_OFF_REMAIN));
      end else begin
        pslverr_q <= 1'b0;
      end
      prdata_q <= 32'h0000_0000;
      if (rd_w) begin
        case (addr)
          ADDR_W'(`RSDX_OFF_FEAT_CUR): prdata_q <= {24'h00_0000, tf_q[0]};
          ADDR_W'(`RSDX_OFF_FEAT_PREV): prdata_q <= {24'h00_0000, tf_q[1]};
          ADDR_W'(`RSDX_OFF_CNT_CUR): prdata_q <= {24'h00_0000, tf_q[2]};
          ADDR_W'(`RSDX_OFF_CNT_PREV): prdata_q <= {24'h00_0000, tf_q[3]};
          // The address registers read back the first failing sector.
          8'h10, 8'h14: prdata_q <= {24'h00_0000, hob_q ? fail_q[31:24] : fail_q[7:0]}; // R3
          8'h18, 8'h1C: prdata_q <= {24'h00_0000, hob_q ? fail_q[39:32] : fail_q[15:8]}; // R3
          8'h20, 8'h24: prdata_q <= {24'h00_0000, hob_q ? fail_q[47:40] : fail_q[23:16]}; // R3
          ADDR_W'(`RSDX_OFF_DEVCTL): prdata_q <= {24'h00_0000, hob_q, 7'h00};
          ADDR_W'(`RSDX_OFF_ERROR): prdata_q <= {24'h00_0000, err_q};
          ADDR_W'(`RSDX_OFF_STATUS): begin
            prdata_q <= 32'h0000_0000;
            prdata_q[`RSDX_ST_BSY_BIT] <= (state_q == RSDX_XFER);
            prdata_q[`RSDX_ST_RDY_BIT] <= 1'b1;
            prdata_q[`RSDX_ST_SERR_BIT] <= sts_serr_q; // R11
            prdata_q[`RSDX_ST_DRQ_BIT] <= (state_q == RSDX_XFER);
            prdata_q[`RSDX_ST_ERR_BIT] <= sts_err_q;
          end
          ADDR_W'(`RSDX_OFF_TUNIT): prdata_q <= {16'h0000, tunit_q};
          ADDR_W'(`RSDX_OFF_IRQ_STAT): prdata_q <= {29'h0000_0000, irq_stat_q};
          ADDR_W'(`RSDX_OFF_IRQ_EN): prdata_q <= {29'h0000_0000, irq_en_q};
          ADDR_W'(`RSDX_OFF_REMAIN): prdata_q <= {15'h0000, rem_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Taskfile and configuration registers
  // --------------------------------------------------------------------------
  // Parameter bytes; writes during a command land but are used only by the
  // next command, since the engine copies everything at the start.
  genvar gi;
  generate
    for (gi = 0; gi < `RSDX_TF_NUM; gi = gi + 1) begin : g_tf
      always_ff @(posedge CLK_SYS or posedge RST) begin
        if (RST) begin
          tf_q[gi] <= 8'h00;
        end else if (wr_w && (addr == ADDR_W'(gi * 4))) begin
          tf_q[gi] <= PWDATA[7:0];
        end
      end
    end
  endgenerate

  // Per-stream default limits, written as stream number plus value.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 8; i++) begin
        dflt_q[i] <= 8'h00;
      end
    end else if (wr_w && (addr == ADDR_W'(`RSDX_OFF_DFLT))) begin
      dflt_q[PWDATA[10:8]] <= PWDATA[7:0];
    end
  end

  // High-byte select and time unit.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      hob_q <= 1'b0;
      tunit_q <= `RSDX_TUNIT_RST;
    end else begin
      if (wr_w && (addr == ADDR_W'(`RSDX_OFF_DEVCTL))) begin
        hob_q <= PWDATA[`RSDX_DEVCTL_HOB_BIT];
      end
      if (wr_w && (addr == ADDR_W'(`RSDX_OFF_TUNIT))) begin
        tunit_q <= PWDATA[15:0];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Completion time limit
  // --------------------------------------------------------------------------
  // A zero request falls back to the stream default; a zero default means
  // the command runs without a limit.
  assign lim_sel = (tf_q[`RSDX_IDX_FEAT_PREV] != 8'h00) ? tf_q[`RSDX_IDX_FEAT_PREV]
                   : dflt_q[tf_q[`RSDX_IDX_FEAT_CUR][2:0]]; // R12 R13
  // Both factors are widened first so the full product fits the timer.
  assign req_us = 24'(lim_sel) * 24'(tunit_q); // R13

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      lim_en_q <= 1'b0;
      lim_us_q <= 24'h00_0000;
    end else if (start_w) begin
      lim_en_q <= (lim_sel != 8'h00);
      lim_us_q <= (req_us < MIN_LIMIT_US) ? MIN_LIMIT_US : req_us; // R15
    end
  end

  // Microsecond timer, running from the command write to the completion.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pre_q <= 5'h00;
      us_cnt_q <= 24'h00_0000;
    end else if (start_w) begin
      pre_q <= 5'h00; // R14
      us_cnt_q <= 24'h00_0000;
    end else if (state_q == RSDX_XFER) begin
      if (pre_q == 5'(`RSDX_CYC_PER_US - 1)) begin
        pre_q <= 5'h00;
        us_cnt_q <= us_cnt_q + 24'h00_0001;
      end else begin
        pre_q <= pre_q + 5'h01;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Command engine
  // --------------------------------------------------------------------------
  assign ack_w = (state_q == RSDX_XFER) & XFER_ACK;
  assign bad_sec = ack_w & (|XFER_ERR);
  assign last_w = ack_w && (rem_q == 17'h0_0001);
  assign to_w = (state_q == RSDX_XFER) && lim_en_q && (us_cnt_q >= lim_us_q); // R8
  // Continuous mode ignores sector errors; only the last sector or the
  // time limit ends it.
  assign stop_w = to_w | (bad_sec & ~cont_q) | last_w; // R5 R7 R9
  always_comb begin
    ev_err = 8'h00;
    ev_err[`RSDX_ERR_ICRC_BIT] = bad_sec & XFER_ERR[3];
    ev_err[`RSDX_ERR_UNC_BIT] = bad_sec & XFER_ERR[2];
    ev_err[`RSDX_ERR_IDNF_BIT] = bad_sec & XFER_ERR[1];
    ev_err[`RSDX_ERR_ABRT_BIT] = bad_sec & XFER_ERR[0];
    ev_err[`RSDX_ERR_TLIM_BIT] = to_w;
  end

  // State, sector address and remaining count.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_q <= RSDX_IDLE;
      cont_q <= 1'b0;
      lba_q <= 48'h0000_0000_0000;
      rem_q <= 17'h0_0000;
    end else begin
      case (state_q)
        RSDX_IDLE: begin
          if (start_w) begin
            state_q <= RSDX_XFER;
            cont_q <= tf_q[`RSDX_IDX_FEAT_CUR][`RSDX_FEAT_CONT_BIT]; // R12
            lba_q <= {tf_q[9], tf_q[7], tf_q[5], tf_q[8], tf_q[6], tf_q[4]}; // R10
            rem_q <= (cnt_w == 16'h0000) ? `RSDX_FULL_COUNT : {1'b0, cnt_w}; // R2
          end
        end
        RSDX_XFER: begin
          if (ack_w) begin
            lba_q <= lba_q + 48'h0000_0000_0001;
            rem_q <= rem_q - 17'h0_0001;
          end
          if (stop_w) begin
            state_q <= RSDX_IDLE;
          end
        end
        default: state_q <= RSDX_IDLE;
      endcase
    end
  end

  // First failing sector address, kept for the whole command.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      seen_q <= 1'b0;
      fail_q <= 48'h0000_0000_0000;
    end else if (start_w) begin
      seen_q <= 1'b0;
    end else if (bad_sec && !seen_q) begin
      seen_q <= 1'b1;
      fail_q <= lba_q; // R3
    end
  end

  // Error log and ending status.
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      err_q <= 8'h00;
      any_err_q <= 1'b0;
      sts_err_q <= 1'b0;
      sts_serr_q <= 1'b0;
    end else if (start_w) begin
      err_q <= 8'h00;
      any_err_q <= 1'b0;
      sts_err_q <= 1'b0;
      sts_serr_q <= 1'b0;
    end else if (bad_w) begin
      err_q <= 8'h04; // Unknown command code aborts.
      sts_err_q <= 1'b1;
    end else if (state_q == RSDX_XFER) begin
      err_q <= err_q | ev_err; // R7 R8 R11
      any_err_q <= any_err_q | bad_sec | to_w;
      if (stop_w) begin
        sts_err_q <= ~cont_q & (any_err_q | bad_sec | to_w); // R5 R6
        sts_serr_q <= cont_q & (any_err_q | bad_sec | to_w); // R6 R7
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupts
  // --------------------------------------------------------------------------
  // Set wins over a clear in the same cycle so no event is lost.
  always_comb begin
    irq_ev = 3'b000;
    irq_ev[`RSDX_IRQ_DONE_BIT] = stop_w | bad_w; // R14
    irq_ev[`RSDX_IRQ_FAIL_BIT] = bad_w | (stop_w & (any_err_q | bad_sec | to_w));
    irq_ev[`RSDX_IRQ_TOUT_BIT] = to_w;
    irq_stat_d = irq_stat_q | irq_ev;
    if (wr_w && (addr == ADDR_W'(`RSDX_OFF_IRQ_CLR))) begin
      irq_stat_d = (irq_stat_q & ~PWDATA[2:0]) | irq_ev;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      irq_stat_q <= 3'b000;
      irq_en_q <= 3'b000;
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_w && (addr == ADDR_W'(`RSDX_OFF_IRQ_EN))) begin
        irq_en_q <= PWDATA[2:0];
      end
      irq_q <= |(irq_stat_d & irq_en_q);
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ = irq_q;
  assign XFER_REQ = (state_q == RSDX_XFER);
  assign XFER_LBA = lba_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_count_zero_full: assert property (@(posedge CLK_SYS) disable iff (RST) // R2
    start_w && (cnt_w == 16'h0000) |=> rem_q == 17'h1_0000)
    else $error("zero count did not load 65536 sectors");
  a_cmd_starts: assert property (@(posedge CLK_SYS) disable iff (RST) // R4
    start_w |=> XFER_REQ && (XFER_LBA == $past({tf_q[9], tf_q[7], tf_q[5],
      tf_q[8], tf_q[6], tf_q[4]})))
    else $error("read stream command did not start at the given address");
  a_plain_err_stop: assert property (@(posedge CLK_SYS) disable iff (RST) // R5
    bad_sec && !cont_q |=> !XFER_REQ && sts_err_q)
    else $error("ordinary read did not stop with error status");
  a_cont_no_err: assert property (@(posedge CLK_SYS) disable iff (RST) // R6
    stop_w && cont_q |=> !sts_err_q && (sts_serr_q == $past(any_err_q | bad_sec | to_w)))
    else $error("continuous read ended with wrong status");
  a_cont_keeps_going: assert property (@(posedge CLK_SYS) disable iff (RST) // R7
    bad_sec && cont_q && !last_w && !to_w |=> XFER_REQ && (err_q != 8'h00))
    else $error("continuous read stopped or lost an error");
  a_timeout_stop: assert property (@(posedge CLK_SYS) disable iff (RST) // R8
    to_w |=> !XFER_REQ && err_q[`RSDX_ERR_TLIM_BIT] && irq_stat_q[`RSDX_IRQ_TOUT_BIT])
    else $error("time limit expiry did not end the command");
  a_fail_addr: assert property (@(posedge CLK_SYS) disable iff (RST) // R3
    bad_sec && !seen_q |=> fail_q == $past(lba_q))
    else $error("first failing address not captured");
  a_err_reserved: assert property (@(posedge CLK_SYS) disable iff (RST) // R11
    err_q[5] == 1'b0 && err_q[3] == 1'b0 && err_q[1] == 1'b0)
    else $error("reserved error bits set");
  a_limit_min: assert property (@(posedge CLK_SYS) disable iff (RST) // R15
    start_w |=> lim_us_q >= MIN_LIMIT_US)
    else $error("time limit below the minimum");
  a_done_irq: assert property (@(posedge CLK_SYS) disable iff (RST) // R14
    stop_w && irq_en_q[`RSDX_IRQ_DONE_BIT] |=> IRQ [*2])
    else $error("completion interrupt missing");
  c_full_run: cover property (@(posedge CLK_SYS) disable iff (RST) last_w && !cont_q);
  c_cont_error: cover property (@(posedge CLK_SYS) disable iff (RST) stop_w && cont_q && any_err_q);
  c_timeout: cover property (@(posedge CLK_SYS) disable iff (RST) to_w && cont_q);
endmodule

// *** verification/rsdx_media_model.sv ***
/*
  Media engine model: answers each sector request after a set delay.
  Assumes the bench sets the delay, the failing sector index and its code.
*/
`timescale 1ns/1ps

module rsdx_media_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input int delay,
  input int err_at,
  input wire logic [3:0] err_code,
  output logic ack,
  output logic [3:0] err
);
  int wait_n;
  int idx;

  // ----------------------------------------------------------
  // Sector answers
  // ----------------------------------------------------------
  // One ack per sector, never back to back. The error lines toggle while
  // they are not valid, so a stale code can never be mistaken for a fresh one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      err <= 4'h0;
      wait_n <= 0;
      idx <= 0;
    end else if (req && !ack && wait_n >= delay) begin
      ack <= 1'b1;
      err <= (idx == err_at) ? err_code : 4'h0;
      wait_n <= 0;
      idx <= idx + 1;
    end else begin
      ack <= 1'b0;
      err <= ~err;
      wait_n <= req ? wait_n + 1 : 0;
      idx <= req ? idx : 0;
    end
  end
endmodule

// *** verification/testbench.sv ***
/*
  Self-checking bench for the streaming read command block.
  Assumes APB is the only host path and the media model answers sectors.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
  logic CLK_SYS, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic XFER_REQ, XFER_ACK, req_d, err_f;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [47:0] XFER_LBA, lba;
  logic [47:0] got_q[$];
  logic [3:0] XFER_ERR, code;
  logic [7:0] err_map [4] = '{8'h04, 8'h10, 8'h40, 8'h80};
  int delay, err_at, n_mismatch, checks, cyc, ex;
  int seed = 54;
  time t0, t_fall;

  rsdx_top #(.MIN_LIMIT_US(24'h00_0002)) dut_u (
    .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .XFER_REQ(XFER_REQ), .XFER_LBA(XFER_LBA),
    .XFER_ACK(XFER_ACK), .XFER_ERR(XFER_ERR));

  rsdx_media_model media_u (
    .clk(CLK_SYS), .rst(RST), .req(XFER_REQ), .delay(delay), .err_at(err_at),
    .err_code(code), .ack(XFER_ACK), .err(XFER_ERR));

  // ----------------------------------------------------------
  // Clock and monitors
  // ----------------------------------------------------------
  // Clock at 25 MHz.
  initial begin
    CLK_SYS = 1'b0;
    forever #20 CLK_SYS = ~CLK_SYS;
  end

  // Sampled mid-cycle so the values seen are those present at the next edge.
  always @(negedge CLK_SYS) begin
    if (XFER_REQ === 1'b1 && XFER_ACK === 1'b1) got_q.push_back(XFER_LBA);
    if (req_d === 1'b1 && XFER_REQ === 1'b0) t_fall = $time - 20;
    req_d = XFER_REQ;
  end

  // ----------------------------------------------------------
  // Bus and command tasks
  // ----------------------------------------------------------
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    // Ready is looked at on the rising edge itself, before the design's flops
    // move, so the request is released only at the edge that takes it.
    do begin
      @(posedge CLK_SYS);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    rd = PRDATA;
    err_f = PSLVERR;
    if (n >= 50) n_mismatch++;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // Loads the parameters, then the command; t0 marks the accepting edge.
  task automatic start(input logic [7:0] fc, fp, input logic [15:0] c,
                       input logic [7:0] op);
    got_q.delete();
    apb(1'b1, 8'h00, {24'h0, fc});
    apb(1'b1, 8'h04, {24'h0, fp});
    apb(1'b1, 8'h08, {24'h0, c[7:0]});
    apb(1'b1, 8'h0C, {24'h0, c[15:8]});
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, 8'h10 + 8'(4 * i), {24'h0, 8'(lba >> (8 * (i / 2) + 24 * (i % 2)))});
    end
    apb(1'b1, 8'h28, {24'h0, op});
    t0 = $time;
  endtask

  // Waits for the end, then checks status, error log, sectors and interrupt.
  task automatic finish(input int n, input logic [7:0] st, er, input int b);
    int k;
    logic [2:0] en;
    k = 0;
    en = ($random(seed) & 1) ? 3'(1 << b) : 3'h0;
    repeat (2) @(posedge CLK_SYS);
    while (XFER_REQ !== 1'b0 && k < 5000) begin
      @(negedge CLK_SYS);
      k++;
    end
    if (k >= 5000) n_mismatch++;
    chk_rd(8'h34, {24'h0, st});
    chk_rd(8'h30, {24'h0, er});
    `CHK(got_q.size(), n)
    for (int i = 0; i < got_q.size(); i++) `CHK(got_q[i], lba + 48'(i))
    apb(1'b1, 8'h48, {29'h0, en});
    apb(1'b0, 8'h40, 32'h0);
    `CHK(rd[b], 1'b1)
    `CHK(IRQ, en != 3'h0)
    apb(1'b1, 8'h44, 32'h0000_0007);
    chk_rd(8'h40, 32'h0);
    `CHK(IRQ, 1'b0)
    $display("command test done t=%0t", $time);
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------
  // About eight times the expected run; a hang counts as a mismatch.
  initial begin
    #400_000;
    n_mismatch++;
    summarize();
  end

  initial begin
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {delay, err_at, code, lba, n_mismatch, checks} = {32'd0, -32'sd1, 4'h0, 48'h0, 64'd0};
    RST = 1'b1;
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
    chk_rd(8'h34, 32'h0000_0040);
    chk_rd(8'h30, 32'h0);
    chk_rd(8'h38, 32'h0000_0001);
    apb(1'b0, 8'h50, 32'h0);
    `CHK(err_f, 1'b1)
    $display("reset test done");
    // Ordinary reads with random address, length and stream; media delay steps 0 to 3.
    for (int t = 0; t < 4; t++) begin
      delay = t;
      lba = 48'({$random(seed), $random(seed)});
      ex = 1 + ($random(seed) & 3);
      start(8'($random(seed)) & 8'h87, 8'h00, 16'(ex), 8'h2A);
      finish(ex, 8'h40, 8'h00, 0);
    end
    // Continuous reads run to the end whatever error type the media reports.
    err_at = 1;
    for (int k = 0; k < 4; k++) begin
      code = 4'(1 << k);
      start(8'h40, 8'h00, 16'h0003, 8'h2A);
      finish(3, 8'h60, err_map[k], 0);
    end
    // An ordinary read stops at the failing sector and reports its address.
    code = 4'h4;
    start(8'h00, 8'h00, 16'h0004, 8'h2A);
    finish(2, 8'h41, 8'h40, 1);
    for (int h = 0; h < 2; h++) begin
      apb(1'b1, 8'h2C, h ? 32'h0000_0080 : 32'h0);
      for (int i = 0; i < 3; i++) begin
        chk_rd(8'h10 + 8'(8 * i), {24'h0, 8'((lba + 48'h1) >> (8 * i + 24 * h))});
      end
    end
    err_at = -1;
    start(8'h00, 8'h00, 16'h0001, 8'h25);
    finish(0, 8'h41, 8'h04, 1);
    // Stalled media: limit raised to the minimum, then scaled by the time unit.
    delay = 100000;
    for (int j = 0; j < 2; j++) begin
      apb(1'b1, 8'h38, 32'(j + 1));
      start(j ? 8'h40 : 8'h00, 8'(1 + 2 * j), 16'(j * 16'h0102), 8'h2A);
      chk_rd(8'h4C, j ? 32'h0000_0102 : 32'h0001_0000);
      apb(1'b0, 8'h34, 32'h0);
      `CHK(rd[7], 1'b1)
      finish(0, j ? 8'h60 : 8'h41, 8'h01, 2);
      cyc = int'((t_fall - t0) / 40);
      ex = (j ? 6 : 2) * 25;
      `CHK(cyc >= ex && cyc <= ex + 2, 1'b1)
    end
    summarize();
  end
endmodule
